// ===== rtl/card_select_and_irq_flags.sv
// Contract
// - Select 00 routes UART nowhere, 01 to external interface, 1X to internal slot.
// - Writing select only routes the UART; it never starts activation.
// - Bypass set: I/O line follows control register data and direction bits.
// - Reading flags returns pending causes and clears the read-cleared flags.
// - Each cause is individually maskable by a matching enable bit.
// - Flags other than card detect (bit 6) reflect only events of the currently selected interface.
// - Bit 7 sets on wait timeout outside sync mode, on length done in sync mode; read clears.
// - Bit 6 sets on card detect event, works regardless of clock gating; read clears.
// - Bit 5 sets when supply stable timer expires; read clears.
// - Bit 4 follows receive FIFO not empty; flag read does not clear it.
// - In bypass, bit 4 is raised on each falling edge of selected I/O.
// - Bit 3 sets when tx empty or full rises; tx control read clears.
// - Bit 2 sets per byte sent incl. CRC, not on T=0 break; read clears.
// - Bit 1 sets on break or tx underrun; tx control read clears.
// - Bit 0 sets on rx overrun or parity error; rx control read clears.
// - A disabled cause still sets its flag but raises no interrupt.
//
// Decided for this implementation: strobed register access.
module card_select_and_irq_flags
  import card_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire iface_events_t int_events,
  input wire iface_events_t ext_events,
  input wire logic sync_mode,
  input wire logic t0_mode,
  input wire logic break_detect_en,
  input wire logic tx_control_read,
  input wire logic rx_control_read,
  input wire logic card_detect_pin,
  input wire line_ctrl_t int_card_ctrl,
  input wire line_ctrl_t ext_card_ctrl,
  input wire logic uart_io_out,
  input wire logic uart_io_oe,
  input wire logic int_card_io_in,
  input wire logic ext_card_io_in,
  output logic int_card_io_out,
  output logic int_card_io_oe,
  output logic ext_card_io_out,
  output logic ext_card_io_oe,
  output logic uart_io_in,
  output logic uart_to_int,
  output logic uart_to_ext,
  output logic bypass_active,
  output logic card_irq
);

  logic [DATA_W-1:0] card_select_reg;
  logic [DATA_W-1:0] card_select_next;
  logic [DATA_W-1:0] card_irq_flags;
  logic [DATA_W-1:0] card_irq_flags_next;
  logic [DATA_W-1:0] card_irq_enable_reg;
  logic [DATA_W-1:0] card_irq_enable_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic int_io_out_reg;
  logic int_io_oe_reg;
  logic ext_io_out_reg;
  logic ext_io_oe_reg;
  logic uart_io_in_reg;
  logic uart_to_int_reg;
  logic uart_to_ext_reg;
  logic bypass_reg;
  logic irq_reg;
  logic sel_io_last_reg;
  logic tx_empty_last_reg;
  logic tx_full_last_reg;

  route_t route;
  logic [1:0] interface_select;
  logic bypass_sel;
  logic hit_select;
  logic hit_flags;
  logic hit_enable;
  logic flags_read;
  iface_events_t ev;
  logic sel_io_in;
  logic sel_io_fall;
  logic card_event_pulse;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] level_mask;
  logic [DATA_W-1:0] level_val;

  card_event_sync u_card_event_sync (
    .clk(clk),
    .rst_b(rst_b),
    .card_detect_pin(card_detect_pin),
    .change_pulse(card_event_pulse)
  );

  // Register decode
  assign hit_select = reg_addr == CARD_SELECT_OFFSET;
  assign hit_flags = reg_addr == CARD_IRQ_FLAGS_OFFSET;
  assign hit_enable = reg_addr == CARD_IRQ_ENABLE_OFFSET;
  assign flags_read = reg_read && hit_flags;

  // Select register only stores routing; no activation strobe leaves here
  assign card_select_next = (reg_write && hit_select) ?
                            (reg_wdata & SELECT_WRITE_MASK) : card_select_reg;
  assign card_irq_enable_next = (reg_write && hit_enable) ? reg_wdata : card_irq_enable_reg;

  assign interface_select = card_select_reg[SEL_HI_BIT:SEL_LO_BIT];
  assign bypass_sel = card_select_reg[BYPASS_BIT];
  assign route = interface_select[1] ? ROUTE_INT :
                 (interface_select == IFACE_EXT) ? ROUTE_EXT : ROUTE_NONE;

  // Events of the unselected interface are blocked
  always_comb begin
    ev = '0;
    case (route)
      ROUTE_INT: ev = int_events;
      ROUTE_EXT: ev = ext_events;
      ROUTE_NONE: ev = '0;
      default: ev = '0;
    endcase
  end

  always_comb begin
    sel_io_in = 1'b1;
    case (route)
      ROUTE_INT: sel_io_in = int_card_io_in;
      ROUTE_EXT: sel_io_in = ext_card_io_in;
      ROUTE_NONE: sel_io_in = 1'b1;
      default: sel_io_in = 1'b1;
    endcase
  end

  // Idle-high line, so the start bit shows as a fall
  assign sel_io_fall = sel_io_last_reg && !sel_io_in;

  assign set_vec[WAIT_BIT] = sync_mode ? ev.length_done : ev.wait_timeout;
  // Card detect is outside the interface routing and the clock gate
  assign set_vec[CARD_EVT_BIT] = card_event_pulse;
  assign set_vec[SUPPLY_BIT] = ev.supply_timeout;
  assign set_vec[RX_AVAIL_BIT] = bypass_sel && sel_io_fall;
  assign set_vec[TX_EVT_BIT] = (ev.tx_empty_flag && !tx_empty_last_reg) ||
                               (ev.tx_full_flag && !tx_full_last_reg);
  assign set_vec[TX_DONE_BIT] = (ev.byte_sent &&
                                 !(t0_mode && break_detect_en && ev.break_detected)) ||
                                ev.crc_sent;
  assign set_vec[TX_ERR_BIT] = ev.break_detected || ev.tx_underrun;
  assign set_vec[RX_ERR_BIT] = ev.rx_overrun || ev.rx_parity_err;

  assign clr_vec[WAIT_BIT] = flags_read;
  assign clr_vec[CARD_EVT_BIT] = flags_read;
  assign clr_vec[SUPPLY_BIT] = flags_read;
  // Bypass-mode receive flag has no FIFO to empty, so a flag read clears it
  assign clr_vec[RX_AVAIL_BIT] = bypass_sel && flags_read;
  assign clr_vec[TX_EVT_BIT] = tx_control_read;
  assign clr_vec[TX_DONE_BIT] = flags_read;
  assign clr_vec[TX_ERR_BIT] = tx_control_read;
  assign clr_vec[RX_ERR_BIT] = rx_control_read;

  // Outside bypass the receive flag is a level tracking FIFO occupancy
  assign level_mask = bypass_sel ? READ_ZERO : (FLAGS_RESET | (8'h01 << RX_AVAIL_BIT));
  assign level_val = ev.rx_fifo_nonempty ? level_mask : READ_ZERO;

  // Set wins over clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flag
      assign card_irq_flags_next[gi] = level_mask[gi] ? level_val[gi] :
                                       (set_vec[gi] ||
                                        (card_irq_flags[gi] && !clr_vec[gi]));
    end
  endgenerate

  // Read data returns the state before this read's clear takes effect
  always_comb begin
    rdata_next = READ_ZERO;
    if (reg_read) begin
      if (hit_select) begin
        rdata_next = card_select_reg;
      end else if (hit_flags) begin
        rdata_next = card_irq_flags;
      end else if (hit_enable) begin
        rdata_next = card_irq_enable_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      card_select_reg <= SELECT_RESET;
    end else begin
      card_select_reg <= card_select_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      card_irq_flags <= FLAGS_RESET;
    end else begin
      card_irq_flags <= card_irq_flags_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      card_irq_enable_reg <= ENABLE_RESET;
    end else begin
      card_irq_enable_reg <= card_irq_enable_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_io_last_reg <= 1'b1;
    end else begin
      sel_io_last_reg <= sel_io_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_empty_last_reg <= 1'b0;
    end else begin
      tx_empty_last_reg <= ev.tx_empty_flag;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_full_last_reg <= 1'b0;
    end else begin
      tx_full_last_reg <= ev.tx_full_flag;
    end
  end

  // Built from next-state values so the output tracks the flags with no extra lag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(card_irq_flags_next & card_irq_enable_next);
    end
  end

  // I/O routing; output path costs a cycle to keep outputs registered
  logic int_out_next;
  logic int_oe_next;
  logic ext_out_next;
  logic ext_oe_next;
  logic uart_in_next;

  assign int_out_next = bypass_sel ? int_card_ctrl.data : uart_io_out;
  assign int_oe_next = (route == ROUTE_INT) &&
                       (bypass_sel ? int_card_ctrl.drive_en : uart_io_oe);
  assign ext_out_next = bypass_sel ? ext_card_ctrl.data : uart_io_out;
  assign ext_oe_next = (route == ROUTE_EXT) &&
                       (bypass_sel ? ext_card_ctrl.drive_en : uart_io_oe);
  assign uart_in_next = bypass_sel ? 1'b1 : sel_io_in;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_io_out_reg <= 1'b1;
    end else begin
      int_io_out_reg <= int_out_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_io_oe_reg <= 1'b0;
    end else begin
      int_io_oe_reg <= int_oe_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_io_out_reg <= 1'b1;
    end else begin
      ext_io_out_reg <= ext_out_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_io_oe_reg <= 1'b0;
    end else begin
      ext_io_oe_reg <= ext_oe_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_io_in_reg <= 1'b1;
    end else begin
      uart_io_in_reg <= uart_in_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_to_int_reg <= 1'b0;
    end else begin
      uart_to_int_reg <= (route == ROUTE_INT) && !bypass_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_to_ext_reg <= 1'b0;
    end else begin
      uart_to_ext_reg <= (route == ROUTE_EXT) && !bypass_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_reg <= 1'b0;
    end else begin
      bypass_reg <= bypass_sel;
    end
  end

  assign reg_rdata = rdata_reg;
  assign int_card_io_out = int_io_out_reg;
  assign int_card_io_oe = int_io_oe_reg;
  assign ext_card_io_out = ext_io_out_reg;
  assign ext_card_io_oe = ext_io_oe_reg;
  assign uart_io_in = uart_io_in_reg;
  assign uart_to_int = uart_to_int_reg;
  assign uart_to_ext = uart_to_ext_reg;
  assign bypass_active = bypass_reg;
  assign card_irq = irq_reg;

endmodule

// ===== rtl/card_irq_pkg.sv
package card_irq_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] CARD_SELECT_OFFSET = 16'hfe00;
  localparam logic [ADDR_W-1:0] CARD_IRQ_FLAGS_OFFSET = 16'hfe01;
  localparam logic [ADDR_W-1:0] CARD_IRQ_ENABLE_OFFSET = 16'hfe02;

  localparam logic [DATA_W-1:0] SELECT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Field positions in the select register
  localparam int SEL_HI_BIT = 3;
  localparam int SEL_LO_BIT = 2;
  localparam int BYPASS_BIT = 1;
  localparam logic [DATA_W-1:0] SELECT_WRITE_MASK = 8'h0e;

  // Flag bit positions, shared by flags and enable register
  localparam int WAIT_BIT = 7;
  localparam int CARD_EVT_BIT = 6;
  localparam int SUPPLY_BIT = 5;
  localparam int RX_AVAIL_BIT = 4;
  localparam int TX_EVT_BIT = 3;
  localparam int TX_DONE_BIT = 2;
  localparam int TX_ERR_BIT = 1;
  localparam int RX_ERR_BIT = 0;

  // Interface select encodings
  localparam logic [1:0] IFACE_NONE = 2'h0;
  localparam logic [1:0] IFACE_EXT = 2'h1;

  typedef enum logic [2:0] {
    ROUTE_NONE = 3'b001,
    ROUTE_EXT = 3'b010,
    ROUTE_INT = 3'b100
  } route_t;

  // Per-interface event bundle from the internal slot or the external interface
  typedef struct packed {
    logic wait_timeout;
    logic length_done;
    logic supply_timeout;
    logic rx_fifo_nonempty;
    logic tx_empty_flag;
    logic tx_full_flag;
    logic byte_sent;
    logic crc_sent;
    logic break_detected;
    logic tx_underrun;
    logic rx_overrun;
    logic rx_parity_err;
  } iface_events_t;

  // Direct line control bits of one card control register
  typedef struct packed {
    logic data;
    logic drive_en;
  } line_ctrl_t;

endpackage

// ===== rtl/card_event_sync.sv
// Catches card detect pin changes; two-stage sync then edge detect.
module card_event_sync
  import card_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic card_detect_pin,
  output logic change_pulse
);

  localparam int WARM_STAGES = 3;

  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic [WARM_STAGES-1:0] warm_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      warm_reg <= '0;
    end else begin
      meta_reg <= card_detect_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      warm_reg <= {warm_reg[WARM_STAGES-2:0], 1'b1};
    end
  end

  // Insert, removal and fault all show as a transition on the pin
  // Held off until last_reg holds a real pin sample: a pin high at reset is no event
  assign change_pulse = warm_reg[WARM_STAGES-1] && (sync_reg ^ last_reg);

endmodule

// ===== bench/card_side_model.sv
module card_side_model (
  input wire logic int_io_out,
  input wire logic int_io_oe,
  input wire logic ext_io_out,
  input wire logic ext_io_oe,
  input wire logic [1:0] card_low,
  output logic int_io_in,
  output logic ext_io_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Open-drain line with pull-up: any party pulling low wins, a released line reads 1
  assign int_io_in = !(card_low[0] || (int_io_oe && !int_io_out));
  assign ext_io_in = !(card_low[1] || (ext_io_oe && !ext_io_out));
endmodule

// ===== bench/card_select_and_irq_flags_assertions.sv
module card_irq_checker
  import card_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire iface_events_t int_events,
  input wire iface_events_t ext_events,
  input wire logic sync_mode,
  input wire logic card_detect_pin,
  input wire logic uart_to_int,
  input wire logic uart_to_ext,
  input wire logic bypass_active,
  input wire logic card_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] en_q;
  wire map_hit = reg_addr inside {CARD_SELECT_OFFSET, CARD_IRQ_FLAGS_OFFSET,
    CARD_IRQ_ENABLE_OFFSET};
  // Shadow of the enable register so irq relations can be qualified by the mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= ENABLE_RESET;
    end else if (reg_write && reg_addr == CARD_IRQ_ENABLE_OFFSET) begin
      en_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_sel_wr;
    reg_write && reg_addr == CARD_SELECT_OFFSET;
  endsequence
  sequence s_rx_held;
    (en_q[RX_AVAIL_BIT] && uart_to_int && int_events.rx_fifo_nonempty) [*3];
  endsequence
  property p_route;
    logic [DATA_W-1:0] d;
    (s_sel_wr, d = reg_wdata) |-> ##2 {uart_to_int, uart_to_ext} ==
      (d[BYPASS_BIT] ? 2'b00 : {d[SEL_HI_BIT], d[3:2] == IFACE_EXT});
  endproperty
  property p_bypass;
    logic [DATA_W-1:0] d;
    (s_sel_wr, d = reg_wdata) |-> ##2 bypass_active == d[BYPASS_BIT];
  endproperty
  property p_wait;
    en_q[WAIT_BIT] && uart_to_int && !sync_mode && int_events.wait_timeout && !reg_write
      |=> card_irq;
  endproperty
  property p_card;
    en_q[CARD_EVT_BIT] && $changed(card_detect_pin) |-> ##[2:4] card_irq;
  endproperty
  property p_rxav;
    s_rx_held |-> card_irq;
  endproperty
  property p_rx_error_flag;
    en_q[RX_ERR_BIT] && uart_to_ext && ext_events.rx_overrun |=> card_irq;
  endproperty
  property p_unmapped;
    reg_read && !map_hit |=> reg_rdata == READ_ZERO;
  endproperty
  property p_idle;
    !reg_read |=> reg_rdata == READ_ZERO;
  endproperty
  property p_masked;
    en_q == ENABLE_RESET |-> !card_irq;
  endproperty
  a_route: assert property (p_route) else $error("route flags wrong");
  a_bypass: assert property (p_bypass) else $error("bypass flag wrong");
  a_wait: assert property (p_wait) else $error("wait irq missing");
  a_card: assert property (p_card) else $error("card irq missing");
  a_rxav: assert property (p_rxav) else $error("rx irq missing");
  a_rx_error_flag: assert property (p_rx_error_flag) else $error("rx error irq missing");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_idle: assert property (p_idle) else $error("read data not zero");
  a_masked: assert property (p_masked) else $error("masked irq raised");
endmodule

// ===== bench/card_select_and_irq_flags_bench.sv
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module card_select_and_irq_flags_bench
  import card_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, sync_mode = 0, t0 = 0, bk_en = 0;
  logic txr = 0, rxr = 0, cdp = 0, i_out, i_oe, e_out, e_oe, i_in, e_in, byp, irq;
  logic to_int, to_ext, uart_in, u_out = 1, u_oe = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  iface_events_t ie = '0, ee = '0;
  line_ctrl_t ic = '0, ec = '0;
  logic [1:0] card_low = '0;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  localparam logic [ADDR_W-1:0] SEL = CARD_SELECT_OFFSET, FL = CARD_IRQ_FLAGS_OFFSET;
  localparam logic [ADDR_W-1:0] EN = CARD_IRQ_ENABLE_OFFSET;
  always #25 clk = ~clk;
  card_select_and_irq_flags u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata), .int_events(ie),
    .ext_events(ee), .sync_mode(sync_mode), .t0_mode(t0), .break_detect_en(bk_en),
    .tx_control_read(txr), .rx_control_read(rxr), .card_detect_pin(cdp),
    .int_card_ctrl(ic), .ext_card_ctrl(ec), .uart_io_out(u_out), .uart_io_oe(u_oe),
    .int_card_io_in(i_in), .ext_card_io_in(e_in), .int_card_io_out(i_out),
    .int_card_io_oe(i_oe), .ext_card_io_out(e_out), .ext_card_io_oe(e_oe),
    .uart_io_in(uart_in),
    .uart_to_int(to_int), .uart_to_ext(to_ext), .bypass_active(byp), .card_irq(irq));
  card_side_model u_card (.int_io_out(i_out), .int_io_oe(i_oe), .ext_io_out(e_out),
    .ext_io_oe(e_oe), .card_low(card_low), .int_io_in(i_in), .ext_io_in(e_in));
  task give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 `CHK("reg_rdata", e, rdata)
  endtask
  task pulse(input logic [11:0] mi, input logic [11:0] me);
    @(posedge clk) {ie, ee} <= {ie | mi, ee | me};
    @(posedge clk) {ie, ee} <= {ie & ~mi, ee & ~me};
    #1;
  endtask
  task ctl_rd(input logic [1:0] m);
    @(posedge clk) {rxr, txr} <= m;
    @(posedge clk) {rxr, txr} <= 2'b00;
  endtask
  task t_reset;
    #1 `CHK("card_irq", 1'b0, irq)
    rd_chk(SEL, SELECT_RESET);
    rd_chk(FL, FLAGS_RESET);
    rd_chk(EN, ENABLE_RESET);
    rd_chk(16'hfe05, READ_ZERO);
  endtask
  task t_route;
    for (int i = 0; i < 4; i++) begin
      wr_reg(SEL, 8'(i * 4));
      @(posedge clk) #1 `CHK("route", (i > 1) ? 2'b10 : 2'(i), {to_int, to_ext})
      `CHK("int_card_io_oe", 1'b0, i_oe)
    end
    // UART pulls the routed line low; only the routed pin drives, and its level returns
    @(posedge clk) {u_out, u_oe} <= 2'b01;
    repeat (2) @(posedge clk);
    #1 `CHK("int_io_uart_in", 4'b1000, {i_oe, i_out, e_oe, uart_in})
    wr_reg(SEL, 8'h04);
    repeat (2) @(posedge clk);
    #1 `CHK("ext_io_uart_in", 4'b0100, {i_oe, e_oe, e_out, uart_in})
    @(posedge clk) u_oe <= 1'b0;
    wr_reg(SEL, 8'hff);
    rd_chk(SEL, SELECT_WRITE_MASK);
  endtask
  task t_flags;
    wr_reg(SEL, 8'h08);
    wr_reg(EN, 8'h00);
    pulse(12'h200, 12'h000);
    `CHK("card_irq", 1'b0, irq)
    rd_chk(FL, 8'h20);
    rd_chk(FL, 8'h00);
    wr_reg(EN, 8'hff);
    pulse(12'h800, 12'h000);
    `CHK("card_irq", 1'b1, irq)
    rd_chk(FL, 8'h80);
    `CHK("card_irq", 1'b0, irq)
    @(posedge clk) sync_mode <= 1'b1;
    pulse(12'h800, 12'h000);
    rd_chk(FL, 8'h00);
    pulse(12'h400, 12'h000);
    rd_chk(FL, 8'h80);
    @(posedge clk) sync_mode <= 1'b0;
  endtask
  task t_errors;
    pulse(12'h000, 12'h002);
    rd_chk(FL, 8'h00);
    wr_reg(SEL, 8'h04);
    pulse(12'h000, 12'h002);
    pulse(12'h000, 12'h001);
    rd_chk(FL, 8'h01);
    rd_chk(FL, 8'h01);
    ctl_rd(2'b10);
    rd_chk(FL, 8'h00);
    wr_reg(SEL, 8'h08);
    pulse(12'h004, 12'h000);
    rd_chk(FL, 8'h02);
    ctl_rd(2'b01);
    rd_chk(FL, 8'h00);
  endtask
  task t_tx;
    for (int i = 0; i < 2; i++) begin
      pulse(12'h040 << i, 12'h000);
      rd_chk(FL, 8'h08);
      ctl_rd(2'b01);
      rd_chk(FL, 8'h00);
    end
    pulse(12'h020, 12'h000);
    rd_chk(FL, 8'h04);
    pulse(12'h010, 12'h000);
    rd_chk(FL, 8'h04);
    @(posedge clk) {t0, bk_en} <= 2'b11;
    pulse(12'h028, 12'h000);
    rd_chk(FL, 8'h02);
    ctl_rd(2'b01);
    @(posedge clk) {t0, bk_en} <= 2'b00;
  endtask
  task t_rx;
    @(posedge clk) ie.rx_fifo_nonempty <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("card_irq", 1'b1, irq)
    rd_chk(FL, 8'h10);
    rd_chk(FL, 8'h10);
    @(posedge clk) ie.rx_fifo_nonempty <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(FL, 8'h00);
  endtask
  task t_card;
    @(posedge clk) cdp <= ~cdp;
    repeat (6) @(posedge clk);
    rd_chk(FL, 8'h40);
    rd_chk(FL, 8'h00);
  endtask
  task t_bypass;
    wr_reg(SEL, 8'h0a);
    wr_reg(EN, 8'hef);
    @(posedge clk) ic <= '{data: 1'b0, drive_en: 1'b1};
    repeat (3) @(posedge clk);
    #1 `CHK("int_card_io", 3'b110, {byp, i_oe, i_out})
    `CHK("card_irq", 1'b0, irq)
    rd_chk(FL, 8'h10);
    @(posedge clk) ic.drive_en <= 1'b0;
    repeat (3) @(posedge clk);
    card_low <= 2'b01;
    repeat (3) @(posedge clk);
    rd_chk(FL, 8'h10);
    wr_reg(SEL, 8'h06);
    @(posedge clk) ec <= '{data: 1'b0, drive_en: 1'b1};
    repeat (3) @(posedge clk);
    #1 `CHK("ext_card_io", 3'b110, {uart_in, e_oe, e_out})
    rd_chk(FL, 8'h10);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_route;
    t_flags;
    t_errors;
    t_tx;
    t_rx;
    t_card;
    t_bypass;
    give_verdict;
  end
  // Whole run needs under two hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      give_verdict;
    end
  end
endmodule
bind card_select_and_irq_flags card_irq_checker u_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .int_events(int_events), .ext_events(ext_events),
  .sync_mode(sync_mode), .card_detect_pin(card_detect_pin), .uart_to_int(uart_to_int),
  .uart_to_ext(uart_to_ext), .bypass_active(bypass_active), .card_irq(card_irq));
